// *** sim/arb_host_model.sv ***
// behavioural two-wire bus controller on the device pins
`timescale 1ns/1ps
module arb_host_model (
  // bench clock
  input  wire logic i_clk,
  // bus wires
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  localparam int H = 40;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // data moves an eighth of a bit after the clock fall
  task automatic bit_io(input logic b, output logic r);
    wt(H / 4);
    o_sda_low = !b;
    wt(3 * H / 4);
    o_scl = 1'b1;
    wt(H / 2);
    r = i_sda;
    wt(H / 2);
    o_scl = 1'b0;
  endtask
  task automatic start();
    wt(H / 4);
    o_sda_low = 1'b0;
    wt(3 * H / 4);
    o_scl = 1'b1;
    wt(H);
    o_sda_low = 1'b1;
    wt(H);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    wt(H / 4);
    o_sda_low = 1'b1;
    wt(3 * H / 4);
    o_scl = 1'b1;
    wt(H);
    o_sda_low = 1'b0;
    wt(H);
  endtask
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!ack, r);
  endtask
endmodule

// *** sim/arb_reg_bank_props.sv ***
// port assertions for the converter register bank
`timescale 1ns/1ps
module arb_reg_bank_props #(
  parameter logic [19:0] P_CONV_CYC = arb_pkg::T_CONV_CYC
) (
  // clocks and reset
  input wire logic       i_clk_sys,
  input wire logic       i_clk_link,
  input wire logic       i_rst,
  // bus pins
  input wire logic       i_scl,
  input wire logic       i_sda,
  input wire logic       o_sda,
  input wire logic       o_sda_oe_n,
  // converter core
  input wire logic       o_conv_start,
  input wire logic       i_conv_valid,
  input wire logic [7:0] i_conv_data
);
  // ----------------------------------------------------------------
  // length of a continuous pull-down
  // ----------------------------------------------------------------
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  assign low_cnt_d = o_sda_oe_n ? 8'h00 : low_cnt_q + 8'h01;
  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_d;
  end

  a_start_rst: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $past(i_rst) |-> !o_conv_start) else $error("conversion start right after reset");
  a_start_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_conv_start |=> !o_conv_start [*8]) else $error("conversion starts too close");
  a_start_on_done: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    i_conv_valid |-> !o_conv_start ##1 !o_conv_start) else $error("finished conversion restarts core");
  a_oe_rst: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $past(i_rst) |-> o_sda_oe_n) else $error("data pin driven right after reset");
  a_sda_zero: assert property (@(posedge i_clk_link) disable iff (i_rst)
    o_sda == 1'b0) else $error("data pin output not open drain");
  a_oe_scl_low: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $changed(o_sda_oe_n) |-> !i_scl && !$past(i_scl)) else $error("data changed while clock high");
  a_oe_hold_fall: assert property (@(posedge i_clk_link) disable iff (i_rst)
    $fell(i_scl) |-> $stable(o_sda_oe_n) ##1 $stable(o_sda_oe_n)) else $error("no hold after clock fall");
  a_low_bound: assert property (@(posedge i_clk_link) disable iff (i_rst)
    low_cnt_q < 8'hc8) else $error("data pin held low too long");
endmodule

bind arb_reg_bank arb_reg_bank_props #(.P_CONV_CYC(P_CONV_CYC)) i_arb_reg_bank_props (
  .i_clk_sys, .i_clk_link, .i_rst, .i_scl, .i_sda, .o_sda, .o_sda_oe_n,
  .o_conv_start, .i_conv_valid, .i_conv_data);

// *** sim/arb_reg_bank_test.sv ***
// self-checking bench for the converter register bank
`timescale 1ns/1ps
module arb_reg_bank_test;
  import arb_pkg::*;
  logic       i_clk_sys    = 1'b0;
  logic       i_clk_link   = 1'b0;
  logic       i_rst        = 1'b1;
  logic       scl;
  logic       host_low;
  logic       o_sda;
  logic       o_sda_oe_n;
  logic       o_conv_start;
  logic       i_conv_valid = 1'b0;
  logic [7:0] i_conv_data  = 8'h00;
  wire logic  sda          = !(host_low || !o_sda_oe_n);
  int         seed         = 32'hc13e;
  int         error_cnt    = 0;
  int         comparisons  = 0;
  int         cyc          = 0;
  int         m[8]         = '{0, 0, 0, 0, 255, 0, 255, 0};

  always #2.5 i_clk_sys = ~i_clk_sys;
  initial #3.7 forever #15 i_clk_link = ~i_clk_link;

  arb_reg_bank #(.P_CONV_CYC(20'h4)) i_arb_reg_bank (
    .i_clk_sys, .i_clk_link, .i_rst, .i_scl(scl), .i_sda(sda), .o_sda, .o_sda_oe_n,
    .o_conv_start, .i_conv_valid, .i_conv_data);
  arb_host_model i_arb_host_model (.i_clk(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));

  // ----------------------------------------------------------------
  // reference model and converter stand-in
  // ----------------------------------------------------------------
  task automatic convert(input int v);
    m[0] = v;
    if (v > m[4]) m[1] = m[1] | 2;
    if (v < m[3]) m[1] = m[1] | 1;
    if (m[2][4] == 0 && v + m[5] < m[4]) m[1] = m[1] & 1;
    if (m[2][4] == 0 && v > m[3] + m[5]) m[1] = m[1] & 2;
    m[6] = (v < m[6]) ? v : m[6];
    m[7] = (v > m[7]) ? v : m[7];
  endtask
  always @(negedge i_clk_sys) begin
    if (o_conv_start === 1'b1) begin
      repeat (4) @(negedge i_clk_sys);
      i_conv_data = 8'($random(seed));
      i_conv_valid = 1'b1;
      convert(i_conv_data);
      @(negedge i_clk_sys);
      i_conv_valid = 1'b0;
    end
  end
  function automatic int expv(input int p);
    return (p == 0) ? {m[2][3] && m[1] != 0, 3'h0, m[0][7:0], 4'h0} : m[p];
  endfunction
  task automatic chk_reg(input string name, input int exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp[15:0]) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp[15:0], got);
    end
  endtask
  task automatic chk_ack(input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error ack expected %b seen %b", exp, got);
    end
  endtask
  task automatic send(input logic [7:0] d);
    logic ack;
    i_arb_host_model.put(d, ack);
    chk_ack(1'b1, ack);
  endtask
  task automatic wr(input logic [2:0] p, input logic [7:0] d, input bit has_d);
    i_arb_host_model.start();
    send({DEV_ADDR, 1'b0});
    send({5'h00, p});
    if (has_d) send(d);
    i_arb_host_model.stop();
    if (has_d && p == 3'h1) m[1] = m[1] & ~int'(d);
    else if (has_d && p > 3'h1) m[p] = d;
  endtask
  task automatic rd_chk(input logic [2:0] p, input bit set_p);
    logic [7:0] b1;
    logic [7:0] b0;
    if (set_p) wr(p, 8'h00, 1'b0);
    i_arb_host_model.start();
    send({DEV_ADDR, 1'b1});
    i_arb_host_model.get(p == 3'h0, b1);
    if (p == 3'h0) i_arb_host_model.get(1'b0, b0);
    i_arb_host_model.stop();
    chk_reg($sformatf("reg %0d", p), expv(p), (p == 3'h0) ? {b1, b0} : {8'h00, b1});
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      $display("Error run expected finish seen timeout");
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic nak;
    repeat (6) @(negedge i_clk_sys);
    repeat (3) @(posedge i_clk_link);
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    rd_chk(3'h0, 1'b0);
    for (int p = 1; p < 8; p++) begin
      rd_chk(3'(p), 1'b1);
    end
    // foreign address must be left unanswered
    i_arb_host_model.start();
    i_arb_host_model.put({~DEV_ADDR, 1'b1}, nak);
    i_arb_host_model.stop();
    chk_ack(1'b0, nak);
    $display("reset defaults done");
    wr(3'h0, 8'h5a, 1'b1);
    wr(3'h3, 8'h40, 1'b1);
    wr(3'h4, 8'hc0, 1'b1);
    wr(3'h5, 8'h10, 1'b1);
    wr(3'h2, 8'h08, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd_chk(3'h0, 1'b1);
      rd_chk(3'h1, 1'b1);
      if (i == 1) wr(3'h2, 8'h18, 1'b1);
      if (i == 2) wr(3'h1, 8'h03, 1'b1);
    end
    $display("alert status done");
    // hold kept set so conversions racing the mode write see one hold value
    wr(3'h2, 8'h30, 1'b1);
    repeat (1000) @(negedge i_clk_sys);
    wr(3'h2, 8'h10, 1'b1);
    repeat (300) @(negedge i_clk_sys);
    rd_chk(3'h6, 1'b1);
    rd_chk(3'h7, 1'b1);
    $display("automatic conversion done");
    stop_test();
  end
endmodule

// *** src/arb_pkg.sv ***
// constants shared by the converter register bank
package arb_pkg;

  // ----------------------------------------------------------------
  // register select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PTR_RESULT  = 3'h0;
  localparam logic [2:0] PTR_STATUS  = 3'h1;
  localparam logic [2:0] PTR_CONFIG  = 3'h2;
  localparam logic [2:0] PTR_LOW     = 3'h3;
  localparam logic [2:0] PTR_HIGH    = 3'h4;
  localparam logic [2:0] PTR_HYST    = 3'h5;
  localparam logic [2:0] PTR_LOWEST  = 3'h6;
  localparam logic [2:0] PTR_HIGHEST = 3'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned STS_UNDER_BIT  = 0;
  localparam int unsigned STS_OVER_BIT   = 1;
  localparam int unsigned CFG_MIRROR_BIT = 3;
  localparam int unsigned CFG_HOLD_BIT   = 4;
  localparam int unsigned CFG_CYC_LSB    = 5;
  localparam int unsigned CFG_CYC_MSB    = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_PTR     = 3'h0;
  localparam logic [7:0] RST_CONFIG  = 8'h00;
  localparam logic [1:0] RST_STATUS  = 2'h0;
  localparam logic [7:0] RST_RESULT  = 8'h00;
  localparam logic [7:0] RST_LOW     = 8'h00;
  localparam logic [7:0] RST_HIGH    = 8'hff;
  localparam logic [7:0] RST_HYST    = 8'h00;
  localparam logic [7:0] RST_LOWEST  = 8'hff;
  localparam logic [7:0] RST_HIGHEST = 8'h00;

  // ----------------------------------------------------------------
  // bus address and timing
  // ----------------------------------------------------------------
  // arbitrary bus address
  localparam logic [6:0]  DEV_ADDR    = 7'h2a;
  localparam int unsigned SYS_CLK_MHZ = 200;
  localparam int unsigned T_CONV_NS   = 1000;
  localparam logic [19:0] T_CONV_CYC  = 20'((T_CONV_NS * SYS_CLK_MHZ + 999) / 1000);
  // code 1 gives 32 conversion times, so shift is code plus 4
  localparam logic [4:0]  AUTO_SHIFT  = 5'h04;

endpackage

// *** src/arb_reg_bank.sv ***
// register bank, alert status and two-wire slave of the 8-bit converter
// What this block does
// R1 - reset defaults hold until conversion or write
// R2 - eight data registers, result read-only
// R3 - min, max, thresholds and configuration stored
// R4 - first written byte loads the pointer
// R5 - only three pointer bits select registers
// R6 - host writes zeros in upper pointer bits
// R7 - pointer resets to zero, the result
// R8 - select codes zero to seven map registers
// R9 - result holds latest completed conversion
// R10 - result read starts conversion in normal mode
// R11 - result in bits 11:4, zeros in bits 14:12 and 3:0
// R12 - bit 15 mirrors alerts when enabled
// R13 - alert flags active high
// R14 - over-range sets above high limit
// R15 - under-range sets below low limit
// R16 - writing one clears an alert flag
// R17 - over-range self-clears below high minus hysteresis
// R18 - under-range self-clears above low plus hysteresis
// R19 - alert hold stops self-clearing
// R20 - status bits 7:2 read zero
// R21 - configuration bit 4 is alert hold
// R22 - configuration bits 7:5 select automatic conversion
// R23 - conversion begins at acknowledge fall
// R24 - 16-bit registers sent MSB byte first
// R25 - 8-bit compares without wrap-around
`timescale 1ns/1ps
module arb_reg_bank #(
  parameter logic [19:0] P_CONV_CYC = arb_pkg::T_CONV_CYC
) (
  // clocks and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_clk_link,
  input  wire logic       i_rst,
  // two-wire bus pins
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  // converter core, system clock
  output logic            o_conv_start,
  input  wire logic       i_conv_valid,
  input  wire logic [7:0] i_conv_data
);
  import arb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
  } arb_bus_state_t;

  // ----------------------------------------------------------------
  // system domain: conversion start and automatic timer
  // ----------------------------------------------------------------
  logic        st_s1_q, st_s2_q, st_s3_q;
  logic [2:0]  cyc_s1_q, cyc_s2_q, cyc_s3_q, cyc_q;
  logic [19:0] tmr_q;
  logic        conv_start_q;
  logic [7:0]  cdata_q;
  logic        done_tgl_q;
  logic        start_tgl_q;
  logic [7:0]  cfg_q;

  wire         manual_start = st_s2_q ^ st_s3_q;
  wire         auto_on      = (cyc_q != 3'h0);
  wire [4:0]   auto_shift   = 5'(cyc_q) + AUTO_SHIFT;
  wire [19:0]  auto_period  = 20'(P_CONV_CYC << auto_shift);
  wire         auto_fire    = auto_on && (tmr_q == 20'h00000);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_s1_q  <= 1'b0;
      st_s2_q  <= 1'b0;
      st_s3_q  <= 1'b0;
      cyc_s1_q <= 3'h0;
      cyc_s2_q <= 3'h0;
      cyc_s3_q <= 3'h0;
      cyc_q    <= 3'h0;
    end else begin
      st_s1_q  <= start_tgl_q;
      st_s2_q  <= st_s1_q;
      st_s3_q  <= st_s2_q;
      cyc_s1_q <= cfg_q[CFG_CYC_MSB:CFG_CYC_LSB];
      cyc_s2_q <= cyc_s1_q;
      cyc_s3_q <= cyc_s2_q;
      // multi-bit code taken only once two samples agree
      if (cyc_s2_q == cyc_s3_q) begin
        cyc_q <= cyc_s2_q;
      end
    end
  end

  // periodic conversions while the cycle code is nonzero (see R22)
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tmr_q <= 20'h00000;
    end else if (!auto_on) begin
      tmr_q <= 20'h00000;
    end else if (tmr_q == 20'h00000) begin
      tmr_q <= auto_period - 20'h00001;
    end else begin
      tmr_q <= tmr_q - 20'h00001;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= (manual_start && !auto_on) || auto_fire; // see R10
    end
  end

  // finished conversion held stable while its toggle crosses
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cdata_q    <= RST_RESULT;
      done_tgl_q <= 1'b0;
    end else if (i_conv_valid) begin
      cdata_q    <= i_conv_data;
      done_tgl_q <= ~done_tgl_q;
    end
  end

  assign o_conv_start = conv_start_q;

  // ----------------------------------------------------------------
  // link domain: synchronisers and edge detection
  // ----------------------------------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic dn_s1_q, dn_s2_q, dn_s3_q;

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      dn_s1_q  <= 1'b0;
      dn_s2_q  <= 1'b0;
      dn_s3_q  <= 1'b0;
    end else begin
      scl_s1_q <= i_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= i_sda;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      dn_s1_q  <= done_tgl_q;
      dn_s2_q  <= dn_s1_q;
      dn_s3_q  <= dn_s2_q;
    end
  end

  wire scl_rise  = scl_s2_q && !scl_s3_q;
  wire scl_fall  = !scl_s2_q && scl_s3_q;
  wire bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  wire bus_stop  = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  wire conv_done = dn_s2_q ^ dn_s3_q;

  // ----------------------------------------------------------------
  // link domain: byte engine
  // ----------------------------------------------------------------
  arb_bus_state_t st_q;
  logic [7:0]     sh_q;
  logic [7:0]     tx_q;
  logic [7:0]     tx_lo_q;
  logic [3:0]     cnt_q;
  logic           rw_q;
  logic           first_q;
  logic           lo_q;
  logic           drv_n_q;
  logic [2:0]     ptr_q;
  logic [1:0]     sts_q;
  logic [7:0]     result_q, low_q, high_q, hyst_q, lowest_q, highest_q;

  wire        byte_in    = scl_fall && (cnt_q == 4'h8);
  wire        addr_match = (sh_q[7:1] == DEV_ADDR);
  wire        addr_ack   = (st_q == ST_ADDR) && byte_in && addr_match;
  wire        wr_done    = (st_q == ST_WR) && byte_in;
  wire        ptr_wr     = wr_done && first_q;
  wire        reg_wr     = wr_done && !first_q;
  wire        load_rd    = scl_fall && (((st_q == ST_AACK) && rw_q) || (st_q == ST_RACK));
  wire        alert_any  = |sts_q;
  wire [15:0] result_word = {cfg_q[CFG_MIRROR_BIT] && alert_any, 3'h0, result_q, 4'h0}; // see R11 R12

  // read selection by pointer (see R8 R20)
  logic [7:0] reg_byte;
  always_comb begin
    unique case (ptr_q)
      PTR_RESULT:  reg_byte = result_word[15:8];
      PTR_STATUS:  reg_byte = {6'h00, sts_q};
      PTR_CONFIG:  reg_byte = cfg_q;
      PTR_LOW:     reg_byte = low_q;
      PTR_HIGH:    reg_byte = high_q;
      PTR_HYST:    reg_byte = hyst_q;
      PTR_LOWEST:  reg_byte = lowest_q;
      PTR_HIGHEST: reg_byte = highest_q;
    endcase
  end

  // result word: MSB byte then its captured LSB byte (see R24)
  wire [7:0] rd_byte = (ptr_q == PTR_RESULT && lo_q) ? tx_lo_q : reg_byte;

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      st_q    <= ST_IDLE;
      sh_q    <= 8'h00;
      tx_q    <= 8'h00;
      tx_lo_q <= 8'h00;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      lo_q    <= 1'b0;
      drv_n_q <= 1'b1;
    end else if (bus_start) begin
      st_q    <= ST_ADDR;
      cnt_q   <= 4'h0;
      drv_n_q <= 1'b1;
    end else if (bus_stop) begin
      st_q    <= ST_IDLE;
      drv_n_q <= 1'b1;
    end else begin
      if (load_rd) begin
        tx_q    <= rd_byte;
        drv_n_q <= rd_byte[7];
        lo_q    <= ~lo_q;
        if (!lo_q) begin
          tx_lo_q <= result_word[7:0];
        end
      end
      unique case (st_q)
        ST_IDLE: begin
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_s2_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_in) begin
            cnt_q <= 4'h0;
            if (st_q == ST_WR) begin
              st_q    <= ST_WACK;
              drv_n_q <= 1'b0;
              first_q <= 1'b0;
            end else if (addr_match) begin
              st_q    <= ST_AACK;
              drv_n_q <= 1'b0;
              rw_q    <= sh_q[0];
              first_q <= 1'b1; // see R4
              lo_q    <= 1'b0;
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            st_q <= rw_q ? ST_RD : ST_WR;
            if (!rw_q) begin
              drv_n_q <= 1'b1;
            end
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            st_q    <= ST_WR;
            drv_n_q <= 1'b1;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              st_q    <= ST_RACK;
              drv_n_q <= 1'b1;
              cnt_q   <= 4'h0;
            end else begin
              tx_q    <= {tx_q[6:0], 1'b0};
              drv_n_q <= tx_q[6];
              cnt_q   <= cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            st_q <= ST_RD;
          end else if (scl_rise && sda_s2_q) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign o_sda      = 1'b0;
  assign o_sda_oe_n = drv_n_q;

  // ----------------------------------------------------------------
  // link domain: conversion request at the address acknowledge
  // ----------------------------------------------------------------
  wire cfg_auto = (cfg_q[CFG_CYC_MSB:CFG_CYC_LSB] != 3'h0);

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      start_tgl_q <= 1'b0;
    end else if (addr_ack && sh_q[0] && (ptr_q == PTR_RESULT) && !cfg_auto) begin
      start_tgl_q <= ~start_tgl_q; // see R10 R23
    end
  end

  // ----------------------------------------------------------------
  // link domain: registers
  // ----------------------------------------------------------------
  wire [7:0] cv      = cdata_q;
  wire       hold    = cfg_q[CFG_HOLD_BIT];
  wire       over_s  = conv_done && (cv > high_q);                                      // see R14
  wire       under_s = conv_done && (cv < low_q);                                       // see R15
  wire [8:0] cv_hy   = {1'b0, cv} + {1'b0, hyst_q};
  wire [8:0] low_hy  = {1'b0, low_q} + {1'b0, hyst_q};
  wire       over_c  = conv_done && !hold && (cv_hy < {1'b0, high_q});                  // see R17 R19 R25
  wire       under_c = conv_done && !hold && ({1'b0, cv} > low_hy);                     // see R18 R19 R25
  wire       sts_wr  = reg_wr && (ptr_q == PTR_STATUS);
  wire       over_w  = sts_wr && sh_q[STS_OVER_BIT];                                    // see R16
  wire       under_w = sts_wr && sh_q[STS_UNDER_BIT];
  wire [1:0] sts_d;

  // set wins over any clear in the same cycle (see R13)
  assign sts_d[STS_OVER_BIT]  = over_s || (sts_q[STS_OVER_BIT] && !over_w && !over_c);
  assign sts_d[STS_UNDER_BIT] = under_s || (sts_q[STS_UNDER_BIT] && !under_w && !under_c);

  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      ptr_q <= RST_PTR; // see R7
      sts_q <= RST_STATUS;
    end else begin
      sts_q <= sts_d;
      if (ptr_wr) begin
        ptr_q <= sh_q[2:0]; // see R5 R6
      end
    end
  end

  // defaults stand until a conversion or a write (see R1 R2 R3)
  always_ff @(posedge i_clk_link or posedge i_rst) begin
    if (i_rst) begin
      result_q  <= RST_RESULT;
      cfg_q     <= RST_CONFIG;
      low_q     <= RST_LOW;
      high_q    <= RST_HIGH;
      hyst_q    <= RST_HYST;
      lowest_q  <= RST_LOWEST;
      highest_q <= RST_HIGHEST;
    end else begin
      if (conv_done) begin
        result_q  <= cv; // see R9
        lowest_q  <= (cv < lowest_q) ? cv : lowest_q;
        highest_q <= (cv > highest_q) ? cv : highest_q;
      end else if (reg_wr && ptr_q == PTR_LOWEST) begin
        lowest_q <= sh_q;
      end else if (reg_wr && ptr_q == PTR_HIGHEST) begin
        highest_q <= sh_q;
      end
      if (reg_wr) begin
        unique case (ptr_q)
          PTR_CONFIG: cfg_q  <= sh_q; // see R21 R22
          PTR_LOW:    low_q  <= sh_q;
          PTR_HIGH:   high_q <= sh_q;
          PTR_HYST:   hyst_q <= sh_q;
          default: begin
          end
        endcase
      end
    end
  end

endmodule
